// File: tw_pkg.sv
package tw_pkg;
	// memory locations
	localparam logic [7:0] ADDR_BUS_ADDRESS   = 8'h80;
	localparam logic [7:0] ADDR_FUNC_CMD      = 8'hfe;
	// field layout of the bus address setting
	localparam int         ADDR_FIELD_LSB     = 1;
	localparam int         ADDR_FIELD_W       = 7;
	// factory default bus address, 1011001b
	localparam logic [6:0] FACTORY_ADDRESS    = 7'h59;
	localparam logic [7:0] FACTORY_SETTING    = 8'hb2;
	// copy command for nonvolatile block 1
	localparam logic [7:0] CMD_COPY_BLOCK     = 8'h48;
	localparam logic [7:0] BLOCK1_LOW         = 8'h80;
	localparam logic [7:0] BLOCK1_HIGH        = 8'h9f;
	// reads of the function command location return all ones
	localparam logic [7:0] READ_FILL          = 8'hff;
	localparam int         MEM_DEPTH          = 256;
	localparam int         BITS_PER_BYTE      = 8;
	localparam logic [3:0] ACK_BIT_INDEX      = 4'h8;
	// bus clock limit and the system clock
	localparam int         BUS_MAX_KHZ        = 400;
	localparam int         CLK_MHZ            = 125;
	// fastest bus half period in system cycles, rounded down
	localparam int         HALF_PERIOD_CYC    = (CLK_MHZ * 1000) / (2 * BUS_MAX_KHZ);
endpackage

// File: tw_buf2.sv
`timescale 1ns/10ps
// two-entry buffer between the bus engine and the memory
module tw_buf2 #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	logic [WIDTH-1:0] slot_q [2];
	logic             wr_ptr_q;
	logic             rd_ptr_q;
	logic [1:0]       count_q;
	logic             push;
	logic             pop;

	// handshake terms
	assign in_ready  = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data  = slot_q[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			slot_q[0] <= '0;
			slot_q[1] <= '0;
		end
		else if (push)
			slot_q[wr_ptr_q] <= in_data;
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// File: two_wire_slave_port.sv
`timescale 1ns/10ps
// Functional notes
// [R01] slave only; responds to one programmable 7-bit address on a shared bus
// [R02] data line is input when receiving, open-drain low only when returning
// [R03] any bus clock up to 400kHz works without configuration
// [R04] master starts transactions, makes the clock, START and STOP
// [R05] one bit per clock; data change while clock high is START or STOP
// [R06] bus idle when both lines high; STOP returns bus to idle
// [R07] START is data falling with clock high, STOP data rising
// [R08] repeated START ends one transaction and begins the next
// [R09] acknowledge: pull data low before ninth rising edge until clock falls
// [R10] not-acknowledge: data released through the acknowledge clock
// [R11] master should watch acknowledges and retry failed transfers
// [R12] bytes are eight bits, MSb first, acknowledge after the LSb
// [R13] multibyte values MSB first at the even address
// [R14] while idle, watch for START then a possibly matching address
// [R15] acknowledge on match in the clock period after direction bit
// [R16] bus address defaults to 1011001 and software can change it
// [R17] bus address lives at location 80h and is written there
// [R18] new address takes effect once the write to 80h completes
// [R19] commit address to nonvolatile store only on block 1 copy
// [R20] after power cycle without copy, the committed address returns
// [R21] direction bit 0 selects write, 1 selects read
// [R22] address setting holds the address in bits 7..1, bit 0 reserved
// [R23] master ends a read by not acknowledging the last byte
// [R24] memory address advances after each byte's LSb
// [R25] on mismatch keep data released and ignore traffic until START
// [R26] both bus lines synchronised; edges found on synchronised samples
module two_wire_slave_port #(
	parameter logic [7:0] NV_SETTING_INIT = tw_pkg::FACTORY_SETTING
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic bus_clk_in,
	input  wire logic bus_data_in,
	output logic      bus_data_out,
	output logic      bus_data_oe,
	output logic [6:0] target_bus_address,
	output logic       busy
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_RECV = 5'h04,
		ST_SEND = 5'h08,
		ST_WAIT = 5'h10
	} state_t;

	state_t     state_q;
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic       scl_prev_q;
	logic       sda_prev_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic       is_read_q;
	logic       have_ptr_q;
	logic       ack_phase_q;
	logic       drive_low_q;
	logic       nacked_q;
	logic [7:0] ptr_q;
	logic [7:0] mem_q [tw_pkg::MEM_DEPTH];
	logic [7:0] setting_q;
	logic [7:0] nv_setting_q = NV_SETTING_INIT; // see [R16] [R20]
	logic [7:0] live_setting;
	logic       use_live_q;
	logic [7:0] rd_next;
	logic       wr_valid;
	logic       wr_ready;
	logic [15:0] wr_word;
	logic       mem_valid;
	logic [15:0] mem_word;

	// address field of a setting byte
	function automatic logic [6:0] addr_of(input logic [7:0] s);
		addr_of = s[tw_pkg::ADDR_FIELD_LSB +: tw_pkg::ADDR_FIELD_W];
	endfunction

	// read data, all ones at the function command location
	function automatic logic [7:0] read_byte(input logic [7:0] a,
		input logic [7:0] set);
		if (a == tw_pkg::ADDR_BUS_ADDRESS)
			read_byte = set;
		else if (a == tw_pkg::ADDR_FUNC_CMD)
			read_byte = tw_pkg::READ_FILL;
		else
			read_byte = mem_q[a];
	endfunction

	// both lines through two flops before any logic
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[0], bus_clk_in}; // see [R26]
			sda_sync_q <= {sda_sync_q[0], bus_data_in}; // see [R26]
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	// edge and condition detection on synchronised samples
	assign scl_rise   = scl_sync_q[1] && !scl_prev_q; // see [R05]
	assign scl_fall   = !scl_sync_q[1] && scl_prev_q;
	// sampling at 125MHz leaves margin at the 400kHz limit, see [R03]
	assign start_cond = scl_sync_q[1] && scl_prev_q && sda_prev_q
		&& !sda_sync_q[1]; // see [R07]
	assign stop_cond  = scl_sync_q[1] && scl_prev_q && !sda_prev_q
		&& sda_sync_q[1]; // see [R07]

	// committed copy rules until the address is rewritten, see [R20]
	assign live_setting = use_live_q ? setting_q : nv_setting_q;
	assign target_bus_address = addr_of(live_setting); // see [R22]
	// next byte to return, all ones at the function command location
	assign rd_next = read_byte(ptr_q, live_setting);
	assign busy = (state_q != ST_IDLE);

	// open-drain: only ever drive low, see [R02]
	assign bus_data_out = 1'b0;
	assign bus_data_oe  = drive_low_q;

	// byte protocol engine
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q     <= ST_IDLE;
			bit_cnt_q   <= 4'h0;
			shift_q     <= 8'h00;
			is_read_q   <= 1'b0;
			have_ptr_q  <= 1'b0;
			ack_phase_q <= 1'b0;
			drive_low_q <= 1'b0;
			nacked_q    <= 1'b0;
			ptr_q       <= 8'h00;
		end
		else if (start_cond)
		begin
			// start and repeated start restart address phase, see [R08]
			state_q     <= ST_ADDR; // see [R14]
			bit_cnt_q   <= 4'h0;
			ack_phase_q <= 1'b0;
			drive_low_q <= 1'b0;
			have_ptr_q  <= 1'b0;
		end
		else if (stop_cond)
		begin
			state_q     <= ST_IDLE; // see [R06]
			drive_low_q <= 1'b0;
			ack_phase_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE, ST_WAIT:
				begin
					drive_low_q <= 1'b0; // see [R25]
				end
				ST_ADDR, ST_RECV:
				begin
					if (scl_rise && !ack_phase_q)
					begin
						shift_q   <= {shift_q[6:0], sda_sync_q[1]}; // see [R12]
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					if (scl_fall && !ack_phase_q
						&& bit_cnt_q == tw_pkg::ACK_BIT_INDEX)
					begin
						if (state_q == ST_ADDR)
						begin
							if (shift_q[7:1] == target_bus_address)
							begin
								drive_low_q <= 1'b1; // see [R15] [R01]
								ack_phase_q <= 1'b1;
								is_read_q   <= shift_q[0]; // see [R21]
							end
							else
								state_q <= ST_WAIT; // see [R25]
						end
						else
						begin
							drive_low_q <= wr_ready; // full buffer: NACK, see [R10]
							ack_phase_q <= 1'b1;
						end
					end
					else if (scl_fall && ack_phase_q)
					begin
						// release after ack clock falls, see [R09]
						ack_phase_q <= 1'b0;
						bit_cnt_q   <= 4'h0;
						if (state_q == ST_ADDR && is_read_q)
						begin
							state_q     <= ST_SEND;
							shift_q     <= rd_next;
							drive_low_q <= ~rd_next[7];
						end
						else
						begin
							drive_low_q <= 1'b0;
							state_q     <= ST_RECV;
							if (state_q == ST_RECV && drive_low_q)
							begin
								if (!have_ptr_q)
								begin
									ptr_q      <= shift_q;
									have_ptr_q <= 1'b1;
								end
								else
									ptr_q <= ptr_q + 8'h01; // see [R24]
							end
						end
					end
				end
				ST_SEND:
				begin
					if (scl_fall && !ack_phase_q)
					begin
						if (bit_cnt_q == 4'h7)
						begin
							drive_low_q <= 1'b0; // master acks, see [R23]
							ack_phase_q <= 1'b1;
							ptr_q       <= ptr_q + 8'h01; // see [R24] [R13]
						end
						else
						begin
							shift_q     <= {shift_q[6:0], 1'b0}; // see [R12]
							drive_low_q <= ~shift_q[6];
							bit_cnt_q   <= bit_cnt_q + 4'h1;
						end
					end
					else if (scl_rise && ack_phase_q)
						nacked_q <= sda_sync_q[1];
					else if (scl_fall && ack_phase_q)
					begin
						ack_phase_q <= 1'b0;
						bit_cnt_q   <= 4'h0;
						if (nacked_q)
							state_q <= ST_WAIT; // see [R23]
						else
						begin
							shift_q     <= rd_next;
							drive_low_q <= ~rd_next[7];
						end
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// acknowledged data byte goes to the buffer as address and data
	assign wr_valid = (state_q == ST_RECV) && ack_phase_q && drive_low_q
		&& scl_fall && have_ptr_q;
	assign wr_word  = {ptr_q, shift_q};

	tw_buf2 #(
		.WIDTH (16)
	) u_wr_buf (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_word),
		.out_valid (mem_valid),
		.out_ready (1'b1),
		.out_data  (mem_word)
	);

	// shadow memory writes
	always_ff @(posedge clk)
	begin
		if (mem_valid)
			mem_q[mem_word[15:8]] <= mem_word[7:0];
	end

	// live address setting; rst_b falls back to the committed copy
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			setting_q  <= tw_pkg::FACTORY_SETTING;
			use_live_q <= 1'b0; // see [R20]
		end
		else if (mem_valid && mem_word[15:8] == tw_pkg::ADDR_BUS_ADDRESS)
		begin
			setting_q  <= mem_word[7:0]; // see [R17] [R18]
			use_live_q <= 1'b1;
		end
	end

	// committed copy has no reset, so it outlives rst_b (power cycle)
	always_ff @(posedge clk)
	begin
		if (mem_valid && mem_word[15:8] == tw_pkg::ADDR_FUNC_CMD
			&& mem_word[7:0] == tw_pkg::CMD_COPY_BLOCK)
			nv_setting_q <= live_setting; // see [R19]
	end
endmodule

// File: tw_port_monitor.sv
`timescale 1ns/10ps
// protocol checks at the pins of the slave port
module tw_port_monitor (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       bus_clk_in,
	input  wire logic       bus_data_in,
	input  wire logic       bus_data_out,
	input  wire logic       bus_data_oe,
	input  wire logic [6:0] target_bus_address,
	input  wire logic       busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// pin is open-drain, only ever pulled low
	property p_od; !bus_data_out; endproperty
	a_od: assert property (p_od)
		else $error("data pin driven high");
	// drive starts and ends only while the clock is low
	property p_rise; $rose(bus_data_oe) |-> !bus_clk_in; endproperty
	a_rise: assert property (p_rise)
		else $error("drive began clk high");
	property p_fall; $fell(bus_data_oe) |-> !bus_clk_in; endproperty
	a_fall: assert property (p_fall)
		else $error("drive ended clk high");
	// a driven bit holds through the high phase
	property p_hold;
		$rose(bus_clk_in) && bus_data_oe |-> bus_data_oe [*4];
	endproperty
	a_hold: assert property (p_hold)
		else $error("drive dropped early");
	// busy only from a start condition
	property p_start; $rose(busy) |-> bus_clk_in && !bus_data_in; endproperty
	a_start: assert property (p_start)
		else $error("busy without start");
	// busy ends only by a stop condition
	property p_stop; $fell(busy) |-> bus_clk_in && bus_data_in; endproperty
	a_stop: assert property (p_stop)
		else $error("idle without stop");
	property p_idle; !busy |-> !bus_data_oe; endproperty
	a_idle: assert property (p_idle)
		else $error("drive while idle");
	property p_addr; !$stable(target_bus_address) |-> busy; endproperty
	a_addr: assert property (p_addr)
		else $error("address moved idle");
	// a released reset leaves the port idle and the line free
	property p_rst;
		$rose(rst_b) |-> !busy && !bus_data_oe;
	endproperty
	a_rst: assert property (p_rst)
		else $error("port busy after reset");
	c_ack: cover property ($rose(bus_data_oe));
	c_addr: cover property (!$stable(target_bus_address));
	c_stop: cover property ($fell(busy));
endmodule
bind two_wire_slave_port tw_port_monitor i_mon (
	.clk               (clk),
	.rst_b             (rst_b),
	.bus_clk_in        (bus_clk_in),
	.bus_data_in       (bus_data_in),
	.bus_data_out      (bus_data_out),
	.bus_data_oe       (bus_data_oe),
	.target_bus_address(target_bus_address),
	.busy              (busy)
);

// File: tw_bus_master.sv
`timescale 1ns/10ps
// behavioural bus master, ten system cycles per bus clock
module tw_bus_master (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_o
);
	initial
	begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	// start or repeated start: data falls with the clock high
	task automatic st;
		sda_o = 1'b1;
		w(3);
		scl = 1'b1;
		w(3);
		sda_o = 1'b0;
		w(6);
		scl = 1'b0;
		w(3);
	endtask
	// stop: data rises with the clock high, bus left idle
	task automatic sp;
		sda_o = 1'b0;
		w(3);
		scl = 1'b1;
		w(3);
		sda_o = 1'b1;
		w(6);
	endtask
	// one bit per clock, data moved only while the clock is low
	task automatic bitx(input logic b, output logic r);
		sda_o = b;
		w(3);
		scl = 1'b1;
		w(2);
		r = sda;
		w(2);
		scl = 1'b0;
		w(3);
	endtask
	// msb first, then the ninth clock returns the acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	// not-acknowledge on the last byte hands the line back
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++)
		begin
			bitx(1'b1, r);
			d = {d[6:0], r};
		end
		bitx(last, r);
	endtask
endmodule

// File: two_wire_slave_port_tb.sv
`timescale 1ns/10ps
module two_wire_slave_port_tb;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       scl;
	logic       sda_o;
	logic       oe;
	logic       dout;
	logic       busy;
	logic [6:0] tadr;
	logic [7:0] d;
	int         err_count = 0;
	int         cmp_count = 0;
	// wired-and data line with pull-up
	wire        sda = oe ? (dout & sda_o) : sda_o;
	always #4 clk = ~clk;
	two_wire_slave_port i_dut (
		.clk               (clk),
		.rst_b             (rst_b),
		.bus_clk_in        (scl),
		.bus_data_in       (sda),
		.bus_data_out      (dout),
		.bus_data_oe       (oe),
		.target_bus_address(tadr),
		.busy              (busy)
	);
	tw_bus_master i_m (.clk(clk), .sda(sda), .scl(scl), .sda_o(sda_o));
	task automatic complete_run;
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	// send a byte and compare the acknowledge
	task automatic snd(input logic [7:0] b, input logic e);
		logic k;
		i_m.wbyte(b, k);
		chk("ack", {7'h00, k}, {7'h00, e});
	endtask
	task automatic rst_pulse;
		@(negedge clk);
		rst_b = 1'b0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
	endtask
	task automatic t_mismatch;
		i_m.st();
		snd(8'h24, 1'b0);
		snd(8'h80, 1'b0);
		chk("wait", {7'h00, busy}, 8'h01);
		i_m.sp();
		chk("idle", {7'h00, busy}, 8'h00);
	endtask
	task automatic t_program;
		i_m.st();
		snd({tw_pkg::FACTORY_ADDRESS, 1'b0}, 1'b1);
		snd(tw_pkg::ADDR_BUS_ADDRESS, 1'b1);
		snd(8'h20, 1'b1);
		i_m.sp();
		chk("addr", {1'b0, tadr}, 8'h10);
		i_m.st();
		snd({tw_pkg::FACTORY_ADDRESS, 1'b0}, 1'b0);
		i_m.sp();
	endtask
	// pointer write, repeated start, one byte read back
	task automatic rd(input logic [6:0] a, input logic [7:0] p, e);
		i_m.st();
		snd({a, 1'b0}, 1'b1);
		snd(p, 1'b1);
		i_m.st();
		snd({a, 1'b1}, 1'b1);
		i_m.rbyte(1'b1, d);
		chk("rdata", d, e);
		i_m.sp();
	endtask
	task automatic t_incr;
		i_m.st();
		snd(8'h20, 1'b1);
		snd(8'h7f, 1'b1);
		snd(8'h11, 1'b1);
		snd(8'h30, 1'b1);
		i_m.sp();
		chk("incr", {1'b0, tadr}, 8'h18);
	endtask
	// commit, power cycle, then rewrite without a commit and cycle again
	task automatic t_copy;
		i_m.st();
		snd(8'h30, 1'b1);
		snd(tw_pkg::ADDR_FUNC_CMD, 1'b1);
		snd(tw_pkg::CMD_COPY_BLOCK, 1'b1);
		i_m.sp();
		rd(7'h18, tw_pkg::ADDR_FUNC_CMD, tw_pkg::READ_FILL);
		rst_pulse();
		chk("raddr", {1'b0, tadr}, 8'h18);
		i_m.st();
		snd(8'h30, 1'b1);
		snd(tw_pkg::ADDR_BUS_ADDRESS, 1'b1);
		snd(8'h20, 1'b1);
		i_m.sp();
		chk("live", {1'b0, tadr}, 8'h10);
		rst_pulse();
		chk("naddr", {1'b0, tadr}, 8'h18);
	endtask
	// hang guard, run needs well under 25000 cycles
	initial
	begin
		#200000;
		err_count++;
		complete_run();
	end
	initial
	begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		chk("addr0", {1'b0, tadr}, tw_pkg::FACTORY_SETTING >> 1);
		t_mismatch();
		t_program();
		rd(7'h10, tw_pkg::ADDR_BUS_ADDRESS, 8'h20);
		t_incr();
		t_copy();
		t_mismatch();
		complete_run();
	end
endmodule
